// ===== rtl/dmeap_pkg.sv
// constants, types and register layout of the dme page timing core
package dmeap_pkg;
  // -------------------------------------------------------------------
  // Overview of operation
  // (R1) backoff: base by nonce bit plus random steps
  // (R2) fresh uniform random 0..15 per backoff start
  // (R3) blind receiver about 2 us after sending
  // (R4) break-link timer runs 100 to 105 us
  // (R5) clock transition spacing bounded by min/max windows
  // (R6) data bit from transition inside data window
  // (R7) link-fail inhibit expires 98 to 99 ms
  // (R8) link failed: inhibit expired, link not ok
  // (R9) page reception times out after interval timer
  // (R10) quiet interval after received page before sending
  // (R11) ack counter 0..3, init zero, reset three
  // (R12) rx bits: 48 data, 16 crc, saturate 64
  // (R13) tx bit counter 1..64, done at 64
  // (R14) tx word: page low, crc16 high
  // (R15) five line drive commands
  // (R16) ack request sets outgoing ack bit
  // (R17) send only while enabled and not inhibited
  // (R18) pause control holds page output; done status
  // (R19) blind control makes receiver ignore transitions
  // (R20) power-up condition holds logic, includes low power
  // (R21) capture 5-bit nonce from matching page
  // (R22) starting polarity of page kept as bit
  // (R23) crc16 generated over 48 page bits
  // (R24) windows counted in local clock cycles
  // -------------------------------------------------------------------

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_NS            = 40;
  localparam int BO_BASE1_NS       = 3386;
  localparam int BO_BASE0_NS       = 4454;
  localparam int BO_STEP_NS        = 2120;
  localparam int BLIND_NS          = 2000;
  localparam int BREAK_US          = 100;
  localparam int CLKMIN_NS         = 45;
  localparam int CLKMAX_NS         = 63;
  localparam int DATAMIN_NS        = 15;
  localparam int DATAMAX_NS        = 33;
  localparam int LFI_MS            = 98;
  localparam int INTERVAL_NS       = 7064;
  localparam int SILENT_NS         = 2120;
  localparam int CLKMIN_CYC_DEF    = (CLKMIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLKMAX_CYC_DEF    = (CLKMAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATAMIN_CYC_DEF   = (DATAMIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATAMAX_CYC_DEF   = (DATAMAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int LFI_CYC_DEF       = (LFI_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] BO_BASE1 = 12'((BO_BASE1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BO_BASE0 = 12'((BO_BASE0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BO_STEP  = 12'((BO_STEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BLIND_CYC    = 12'((BLIND_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BREAK_CYC    = 12'((BREAK_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] INTERVAL_CYC = 12'((INTERVAL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SILENT_CYC   = 12'((SILENT_NS + CLK_NS - 1) / CLK_NS);

  // -------------------------------------------------------------------
  // page layout, counters, crc
  // -------------------------------------------------------------------
  localparam logic [6:0]  BITS_DONE    = 7'h40;
  localparam logic [6:0]  TX_BIT_INIT  = 7'h01;
  localparam logic [1:0]  ACK_DONE     = 2'h3;
  localparam int          ACK_POS      = 47;
  localparam int          NONCE_LSB    = 12;
  localparam logic [15:0] CRC_POLY     = 16'h8005;
  localparam logic [15:0] CRC_INIT     = 16'h0000;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_ADV_LO = 8'h08;
  localparam logic [7:0] REG_ADV_HI = 8'h0c;
  localparam logic [7:0] REG_NP_LO  = 8'h10;
  localparam logic [7:0] REG_NP_HI  = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RX_LO  = 8'h1c;
  localparam logic [7:0] REG_RX_HI  = 8'h20;
  localparam logic [7:0] REG_NONCE  = 8'h24;
  localparam int CMD_BACKOFF  = 0;
  localparam int CMD_BREAK    = 1;
  localparam int CMD_LFI      = 2;
  localparam int CMD_RX_INIT  = 3;
  localparam int CMD_ACK_INIT = 4;
  localparam int CMD_NONCE    = 5;

  typedef struct packed {
    logic completeAck;
    logic nonceHigh;
    logic lowPower;
    logic useNextPage;
    logic pageSendPause;
    logic transmitAck;
    logic transmitDisable;
    logic sendAbility;
  } dmeap_ctrl_t;

  typedef struct packed {
    logic [6:0] txBitCnt;
    logic [6:0] rxBitCnt;
    logic [1:0] ackCnt;
    logic [2:0] reserved;
    logic       pagePolarity;
    logic       ackDone;
    logic       powerOn;
    logic       linkFailed;
    logic       lfiExpired;
    logic       silentRunning;
    logic       breakRunning;
    logic       blindRunning;
    logic       backoffRunning;
    logic       rxTimeout;
    logic       pageReceived;
    logic       rxActive;
    logic       pageSendFinished;
  } dmeap_status_t;

  typedef enum logic [4:0] {
    LD_DISABLE    = 5'h01,
    LD_IDLE       = 5'h02,
    LD_MV_END     = 5'h04,
    LD_MV_START   = 5'h08,
    LD_TRANSITION = 5'h10
  } dmeap_line_t;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_BITS  = 5'h04,
    TX_END   = 5'h08,
    TX_DONE  = 5'h10
  } dmeap_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_BITS = 3'h2,
    RX_DONE = 3'h4
  } dmeap_rx_t;
endpackage

// ===== rtl/dmeap_core.sv
// dme page timing, counters, line control and ahb-lite registers
module dmeap_core
  import dmeap_pkg::*;
#(
  parameter int CLK_MIN_CYC  = CLKMIN_CYC_DEF,
  parameter int CLK_MAX_CYC  = CLKMAX_CYC_DEF,
  parameter int DATA_MIN_CYC = DATAMIN_CYC_DEF,
  parameter int DATA_MAX_CYC = DATAMAX_CYC_DEF,
  parameter int LFI_CYC      = LFI_CYC_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxLine,
  input  wire logic        powerGood,
  input  wire logic        techLinkOk,
  output logic             txLine,
  output logic             txDriveEnable,
  output dmeap_line_t      lineDriveCommand,
  output logic             pageSendFinished,
  output logic             powerOn,
  output logic             linkFailed,
  output logic             breakLinkActive
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  localparam logic [11:0] CMIN    = 12'(CLK_MIN_CYC);
  localparam logic [11:0] CMAX    = 12'(CLK_MAX_CYC);
  localparam logic [11:0] DMIN    = 12'(DATA_MIN_CYC);
  localparam logic [11:0] DMAX    = 12'(DATA_MAX_CYC);
  localparam logic [11:0] MV_HOLD = 12'(CLK_MAX_CYC + 1);
  localparam logic [31:0] LFI_LD  = 32'(LFI_CYC);

  typedef struct packed {
    dmeap_ctrl_t ctrl;
    logic [47:0] adv;
    logic [47:0] np;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] hrdata;
    logic        rxSync1;
    logic        rxSync2;
    logic        rxPrev;
    logic        pgSync1;
    logic        pgSync2;
    logic [15:0] lfsr;
    logic [11:0] backoffCnt;
    logic [11:0] blindCnt;
    logic [11:0] breakCnt;
    logic [11:0] intervalCnt;
    logic [11:0] silentCnt;
    logic [31:0] lfiCnt;
    logic        lfiArmed;
    dmeap_tx_t   txState;
    dmeap_line_t lineCmd;
    logic        txLine;
    logic        txEn;
    logic [11:0] phaseCnt;
    logic [6:0]  txBitCnt;
    logic [63:0] txWord;
    logic        pageSendFinished;
    logic [1:0]  ackCnt;
    dmeap_rx_t   rxState;
    logic [11:0] gapCnt;
    logic        sawData;
    logic [6:0]  rxBitCnt;
    logic [63:0] rxWord;
    logic        pageReceived;
    logic        rxTimeout;
    logic        pagePolarity;
    logic [4:0]  rxNonce;
    logic        linkFailed;
    logic        powerOn;
  } dmeap_state_t;

  dmeap_state_t  st;
  dmeap_state_t  next_;
  logic [7:0]    cmd;
  logic          edgeSeen;
  logic          blind;
  logic          halt;
  logic          lfiExpired;
  logic          powerOnNow;
  logic [11:0]   elapsed;
  logic [31:0]   rdata;
  logic [47:0]   page;
  dmeap_status_t stat;

  function automatic logic [11:0] tick(input logic [11:0] c);
    tick = (c == 12'h000) ? 12'h000 : c - 12'h001;
  endfunction

  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = (d[i] ^ c[15]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc16 = c;
  endfunction

  // -------------------------------------------------------------------
  // status and read mux
  // -------------------------------------------------------------------
  assign lfiExpired = st.lfiArmed && (st.lfiCnt == 32'h0);
  assign powerOnNow = !st.pgSync2 || st.ctrl.lowPower; // R20

  always_comb begin
    stat                  = '0;
    stat.txBitCnt         = st.txBitCnt;
    stat.rxBitCnt         = st.rxBitCnt;
    stat.ackCnt           = st.ackCnt;
    stat.pagePolarity     = st.pagePolarity;
    stat.ackDone          = (st.ackCnt == ACK_DONE);
    stat.powerOn          = st.powerOn;
    stat.linkFailed       = st.linkFailed;
    stat.lfiExpired       = lfiExpired;
    stat.silentRunning    = (st.silentCnt != 12'h000);
    stat.breakRunning     = (st.breakCnt != 12'h000);
    stat.blindRunning     = (st.blindCnt != 12'h000);
    stat.backoffRunning   = (st.backoffCnt != 12'h000);
    stat.rxTimeout        = st.rxTimeout;
    stat.pageReceived     = st.pageReceived;
    stat.rxActive         = (st.rxState == RX_BITS);
    stat.pageSendFinished = st.pageSendFinished;
    unique case (haddr[7:0])
      REG_CTRL:   rdata = {24'h000000, st.ctrl};
      REG_ADV_LO: rdata = st.adv[31:0];
      REG_ADV_HI: rdata = {16'h0000, st.adv[47:32]};
      REG_NP_LO:  rdata = st.np[31:0];
      REG_NP_HI:  rdata = {16'h0000, st.np[47:32]};
      REG_STATUS: rdata = stat;
      REG_RX_LO:  rdata = st.rxWord[31:0];
      REG_RX_HI:  rdata = st.rxWord[63:32];
      REG_NONCE:  rdata = {27'h0000000, st.rxNonce};
      default:    rdata = 32'h00000000;
    endcase
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    next_ = st;
    // bus slave: address phase, then write data phase
    if (hsel && hready && htrans[1]) begin
      next_.wrPend = hwrite;
      next_.wrAddr = haddr[7:0];
      if (!hwrite) begin
        next_.hrdata = rdata;
      end
    end else begin
      next_.wrPend = 1'b0;
    end
    cmd = (st.wrPend && st.wrAddr == REG_CMD) ? hwdata[7:0] : 8'h00;
    if (st.wrPend) begin
      unique case (st.wrAddr)
        REG_CTRL:   next_.ctrl = dmeap_ctrl_t'(hwdata[7:0]);
        REG_ADV_LO: next_.adv[31:0] = hwdata;
        REG_ADV_HI: next_.adv[47:32] = hwdata[15:0];
        REG_NP_LO:  next_.np[31:0] = hwdata;
        REG_NP_HI:  next_.np[47:32] = hwdata[15:0];
        default:    next_.wrAddr = st.wrAddr;
      endcase
    end

    // synchronisers and random source
    next_.rxSync1 = rxLine;
    next_.rxSync2 = st.rxSync1;
    next_.rxPrev  = st.rxSync2;
    next_.pgSync1 = powerGood;
    next_.pgSync2 = st.pgSync1;
    next_.powerOn = powerOnNow; // R20
    next_.lfsr    = st.lfsr[0] ? ((st.lfsr >> 1) ^ 16'hb400) : (st.lfsr >> 1); // R2

    // timers
    next_.backoffCnt  = tick(st.backoffCnt);
    next_.blindCnt    = tick(st.blindCnt);
    next_.breakCnt    = tick(st.breakCnt);
    next_.intervalCnt = tick(st.intervalCnt);
    next_.silentCnt   = tick(st.silentCnt);
    next_.lfiCnt      = (st.lfiCnt == 32'h0) ? 32'h0 : st.lfiCnt - 32'h1;
    if (cmd[CMD_BACKOFF]) begin
      next_.backoffCnt = (st.ctrl.nonceHigh ? BO_BASE1 : BO_BASE0)
                         + 12'(st.lfsr[3:0]) * BO_STEP; // R1 R2 R24
    end
    if (cmd[CMD_BREAK]) begin
      next_.breakCnt = BREAK_CYC; // R4
    end
    if (cmd[CMD_LFI]) begin
      next_.lfiCnt   = LFI_LD; // R7
      next_.lfiArmed = 1'b1;
    end
    next_.linkFailed = lfiExpired && !techLinkOk; // R8
    if (cmd[CMD_ACK_INIT]) begin
      next_.ackCnt = 2'h0; // R11
    end

    // transmitter
    halt = !st.ctrl.sendAbility || st.ctrl.transmitDisable || powerOnNow; // R17
    page = st.ctrl.useNextPage ? st.np : st.adv; // R14
    page[ACK_POS] = st.ctrl.transmitAck; // R16
    next_.lineCmd = LD_IDLE;
    unique case (st.txState)
      TX_IDLE: begin
        if (halt) begin
          next_.lineCmd = LD_DISABLE; // R15 R17
        end
        if (!halt && st.silentCnt == 12'h000 && st.backoffCnt == 12'h000) begin // R10 R17
          next_.txWord           = {crc16(page), page}; // R14 R23
          next_.txBitCnt         = TX_BIT_INIT; // R13
          next_.phaseCnt         = 12'h000;
          next_.pageSendFinished = 1'b0;
          next_.txState          = TX_START;
        end
      end
      TX_START: begin
        next_.phaseCnt = st.phaseCnt + 12'h001;
        if (st.phaseCnt == 12'h000) begin
          next_.lineCmd = LD_MV_START; // R15
        end else if (st.phaseCnt == MV_HOLD) begin
          next_.phaseCnt = 12'h000;
          next_.txState  = TX_BITS;
        end
      end
      TX_BITS: begin
        if (st.ctrl.pageSendPause) begin
          next_.lineCmd = LD_IDLE; // R18
        end else begin
          next_.phaseCnt = st.phaseCnt + 12'h001;
          if (st.phaseCnt == 12'h000) begin
            next_.lineCmd = LD_TRANSITION;
          end else if (st.phaseCnt == DMIN && st.txWord[6'(st.txBitCnt - 7'h01)]) begin
            next_.lineCmd = LD_TRANSITION;
          end
          if (st.phaseCnt == CMIN - 12'h001) begin
            next_.phaseCnt = 12'h000;
            if (st.txBitCnt == BITS_DONE) begin
              next_.txState = TX_END; // R13
            end else begin
              next_.txBitCnt = st.txBitCnt + 7'h01; // R13
            end
          end
        end
      end
      TX_END: begin
        next_.phaseCnt = st.phaseCnt + 12'h001;
        if (st.phaseCnt == 12'h000) begin
          next_.lineCmd = LD_MV_END; // R15
        end else if (st.phaseCnt == MV_HOLD) begin
          next_.lineCmd  = LD_TRANSITION;
          next_.blindCnt = BLIND_CYC; // R3
          next_.txState  = TX_DONE;
        end
      end
      TX_DONE: begin
        next_.pageSendFinished = 1'b1; // R18
        if (st.ctrl.completeAck && st.txWord[ACK_POS] && st.ackCnt != ACK_DONE) begin
          next_.ackCnt = st.ackCnt + 2'h1; // R11
        end
        next_.txState = TX_IDLE;
      end
      default: next_.txState = TX_IDLE;
    endcase
    if (halt && st.txState != TX_IDLE) begin
      next_.txState = TX_IDLE; // R17
      next_.lineCmd = LD_DISABLE;
    end
    if (next_.lineCmd == LD_TRANSITION || next_.lineCmd == LD_MV_START || next_.lineCmd == LD_MV_END) begin
      next_.txLine = !st.txLine;
    end
    next_.txEn = (next_.lineCmd != LD_DISABLE);

    // receiver
    blind    = (st.blindCnt != 12'h000) || powerOnNow; // R19
    edgeSeen = (st.rxSync2 != st.rxPrev) && !blind; // R19
    elapsed  = st.gapCnt + 12'h001;
    if (st.gapCnt != 12'hfff) begin
      next_.gapCnt = elapsed;
    end
    if (edgeSeen && elapsed >= CMIN) begin // R5
      next_.gapCnt  = 12'h000;
      next_.sawData = 1'b0;
      if (elapsed > CMAX) begin
        if (st.rxState == RX_BITS && st.rxBitCnt == BITS_DONE) begin
          next_.rxState      = RX_DONE;
          next_.pageReceived = 1'b1;
          next_.silentCnt    = SILENT_CYC; // R10
        end else begin
          next_.rxState      = RX_BITS;
          next_.rxBitCnt     = 7'h00; // R12
          next_.intervalCnt  = INTERVAL_CYC; // R9
          next_.pagePolarity = st.rxSync2; // R22
          next_.pageReceived = 1'b0;
          next_.rxTimeout    = 1'b0;
        end
      end else if (st.rxState == RX_BITS && st.rxBitCnt != BITS_DONE) begin
        next_.rxWord[st.rxBitCnt[5:0]] = st.sawData; // R6 R12
        next_.rxBitCnt = st.rxBitCnt + 7'h01; // R12
      end
    end else if (edgeSeen && elapsed >= DMIN && elapsed <= DMAX) begin
      next_.sawData = 1'b1; // R6
    end
    if (st.rxState == RX_BITS && st.intervalCnt == 12'h001) begin
      next_.rxState   = RX_IDLE; // R9
      next_.rxTimeout = 1'b1;
    end
    if (cmd[CMD_RX_INIT]) begin
      next_.rxBitCnt = 7'h00; // R12
    end
    if (cmd[CMD_NONCE]) begin
      next_.rxNonce = st.rxWord[NONCE_LSB +: 5]; // R21
    end

    // held while power is not good or low power is set
    if (powerOnNow) begin
      next_.rxState     = RX_IDLE; // R20
      next_.backoffCnt  = 12'h000;
      next_.breakCnt    = 12'h000;
      next_.intervalCnt = 12'h000;
      next_.silentCnt   = 12'h000;
      next_.lfiArmed    = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st         <= '0;
      st.txState <= TX_IDLE;
      st.rxState <= RX_IDLE;
      st.lineCmd <= LD_DISABLE;
      st.lfsr    <= LFSR_SEED;
      st.ackCnt  <= ACK_DONE; // R11
      st.txBitCnt <= TX_BIT_INIT;
    end else begin
      st <= next_;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st.hrdata;
  assign txLine           = st.txLine;
  assign txDriveEnable    = st.txEn;
  assign lineDriveCommand = st.lineCmd;
  assign pageSendFinished = st.pageSendFinished;
  assign powerOn          = st.powerOn;
  assign linkFailed       = st.linkFailed;
  assign breakLinkActive  = (st.breakCnt != 12'h000);

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  backoff_range_a: assert property (cmd[CMD_BACKOFF] && !powerOnNow |=> // R1
    st.backoffCnt >= BO_BASE1 && st.backoffCnt <= BO_BASE0 + 12'd15 * BO_STEP)
    else $error("backoff load out of range");
  blind_after_tx_a: assert property (st.txState == TX_END && next_.txState == TX_DONE |=> // R3
    st.blindCnt == BLIND_CYC ##1 st.blindCnt == BLIND_CYC - 12'h001)
    else $error("blind timer not started at end of page");
  break_load_a: assert property (cmd[CMD_BREAK] && !powerOnNow |=> breakLinkActive && st.breakCnt == BREAK_CYC) // R4
    else $error("break link timer not loaded");
  link_fail_a: assert property ($rose(linkFailed) |-> $past(lfiExpired) && !$past(techLinkOk)) // R8
    else $error("link failed without expired inhibit");
  ack_init_a: assert property (cmd[CMD_ACK_INIT] && st.txState != TX_DONE |=> st.ackCnt == 2'h0) // R11
    else $error("ack counter not cleared");
  rx_sat_a: assert property (st.rxBitCnt == BITS_DONE && !cmd[CMD_RX_INIT] && !edgeSeen |=> // R12
    st.rxBitCnt == BITS_DONE) else $error("rx bit counter left saturation");
  tx_cnt_a: assert property (st.txBitCnt >= TX_BIT_INIT && st.txBitCnt <= BITS_DONE) // R13
    else $error("tx bit counter out of range");
  halt_a: assert property (halt |=> lineDriveCommand == LD_DISABLE && st.txState == TX_IDLE) // R17
    else $error("transmission not halted");
  pause_a: assert property (st.ctrl.pageSendPause && st.txState == TX_BITS && !halt |=> // R18
    $stable(st.txBitCnt) && $stable(txLine)) else $error("page output not paused");
  blind_rx_a: assert property (st.blindCnt != 12'h000 && !cmd[CMD_RX_INIT] |=> $stable(st.rxBitCnt)) // R19
    else $error("receiver took bits while blind");
  power_a: assert property (powerOnNow |=> st.txState == TX_IDLE && st.rxState == RX_IDLE) // R20
    else $error("logic not held during power up");

  page_sent_c: cover property (st.txState == TX_END ##1 st.txState == TX_END);
  page_rx_c: cover property ($rose(st.pageReceived));
  rx_timeout_c: cover property ($rose(st.rxTimeout));
  link_fail_c: cover property ($rose(linkFailed));

endmodule // dmeap_core

// ===== test/dmeap_link_partner.sv
// link partner model: sends dme frames on the receive line
module dmeap_link_partner (
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b0;
  // quiet line before the toggle makes it a start delimiter
  task automatic send(input logic [63:0] w, input int n);
    #490;
    line = ~line;
    for (int i = 0; i < n; i++) begin
      #160;
      if (w[i]) line = ~line;
      #160;
      line = ~line;
    end
  endtask
endmodule  // dmeap_link_partner

// ===== test/dmeap_core_tb.sv
// self-checking bench of the dme page timing core
module dmeap_core_tb;
  import dmeap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LFI = 200;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hsel, hwrite, hreadyout, hresp, powerGood, techLinkOk, txLine, txDriveEnable;
  logic        pageSendFinished, powerOn, linkFailed, breakLinkActive, ldDis;
  logic [4:0]  seenCmds;
  wire logic   rxLine;
  dmeap_line_t lineDriveCommand;
  int          fail_count, checks, n;

  always #20 mclk = ~mclk;
  always_comb ldDis = (lineDriveCommand === LD_DISABLE);
  always @(posedge mclk) seenCmds <= rst ? 5'h00 : seenCmds | lineDriveCommand;

  dmeap_core #(.CLK_MIN_CYC(6), .CLK_MAX_CYC(10), .DATA_MIN_CYC(2), .DATA_MAX_CYC(5), .LFI_CYC(LFI)) uut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rxLine(rxLine), .powerGood(powerGood), .techLinkOk(techLinkOk), .txLine(txLine),
    .txDriveEnable(txDriveEnable), .lineDriveCommand(lineDriveCommand),
    .pageSendFinished(pageSendFinished), .powerOn(powerOn), .linkFailed(linkFailed),
    .breakLinkActive(breakLinkActive));
  dmeap_link_partner lp (.line(rxLine));

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdy();
    int k;
    k = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin fail_count++; end_sim(); end
      @(posedge mclk);
    end
  endtask
  // waits on the falling edge so settled values are seen
  task automatic cnt(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 30000) begin @(negedge mclk); c++; end
    if (c >= 30000) begin fail_count++; end_sim(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= 1'b1; hsel <= 1'b1; hsize <= 3'h2;
    rdy();
    htrans <= 2'h0; hwdata <= v; hsel <= 1'b0;
    rdy();
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= 1'b0; hsel <= 1'b1; hsize <= 3'h2;
    rdy();
    htrans <= 2'h0; hsel <= 1'b0;
    rdy();
    v = hrdata;
  endtask

  // -------------------------------------------------------------------
  // tests
  // -------------------------------------------------------------------
  initial begin
    fail_count = 0; checks = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; hsel = 0; hsize = 0;
    powerGood = 1'b1; techLinkOk = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cnt(powerOn, 1'b1, n);
    cnt(powerOn, 1'b0, n); chk(32'(n <= 3), 32'h1);
    rd(REG_CTRL, d); chk(d, 32'h0);
    rd(REG_STATUS, d); chk(32'(d[17:16]), 32'h3);
    rd(8'h3c, d); chk(d, 32'h0);
    $display("test defaults done");
    wr(REG_CTRL, 32'h20); cnt(powerOn, 1'b1, n); chk(32'(n <= 3), 32'h1);
    wr(REG_CTRL, 32'h00); cnt(powerOn, 1'b0, n); chk(32'(n <= 3), 32'h1);
    wr(REG_CMD, 32'h10); rd(REG_STATUS, d); chk(32'(d[17:16]), 32'h0);
    $display("test power and ack done");
    wr(REG_CMD, 32'h02); chk(32'(breakLinkActive), 32'h1);
    cnt(breakLinkActive, 1'b0, n); chk(32'(n >= 2496 && n <= 2625), 32'h1);
    wr(REG_CMD, 32'h04); cnt(linkFailed, 1'b1, n); chk(32'(n >= LFI - 4 && n <= LFI + 2), 32'h1);
    @(posedge mclk); techLinkOk <= 1'b1; cnt(linkFailed, 1'b0, n); chk(32'(n <= 2), 32'h1);
    wr(REG_CMD, 32'h01); rd(REG_STATUS, d); chk(32'(d[4]), 32'h1);
    $display("test timers done");
    wr(REG_CTRL, 32'h01); cnt(pageSendFinished, 1'b1, n); chk(32'(seenCmds), 32'h1f);
    wr(REG_CTRL, 32'h09); repeat (20) @(posedge mclk);
    rd(REG_STATUS, d); chk(32'(d[31:25]), 32'h1);
    repeat (20) @(posedge mclk);
    rd(REG_STATUS, d); chk(32'(d[31:25]), 32'h1);
    wr(REG_CTRL, 32'h03); cnt(ldDis, 1'b1, n); chk(32'(n <= 2), 32'h1);
    chk(32'(txDriveEnable), 32'h0);
    $display("test transmit done");
    wr(REG_CTRL, 32'h00); repeat (100) @(posedge mclk);
    lp.send(64'ha5, 8); repeat (4) @(posedge mclk); rd(REG_STATUS, d);
    chk(32'(d[1]), 32'h1);
    chk(32'(d[12]), 32'h1);
    chk(32'(d[24:18]), 32'h8);
    rd(REG_RX_LO, d); chk(d, 32'h000000a5);
    repeat (200) @(posedge mclk);
    rd(REG_STATUS, d); chk(32'(d[3]), 32'h1);
    lp.send(64'h1f000, 17); repeat (4) @(posedge mclk); rd(REG_STATUS, d);
    chk(32'(d[12]), 32'h0);
    chk(32'(d[24:18]), 32'h11);
    wr(REG_CMD, 32'h20); rd(REG_NONCE, d); chk(d, 32'h1f);
    wr(REG_CMD, 32'h08); rd(REG_STATUS, d); chk(32'(d[24:18]), 32'h0);
    $display("test receive done");
    end_sim();
  end
endmodule  // dmeap_core_tb
